// File: common/ccs_pkg.sv
package ccs_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [4:0] ADR_MODE    = 5'h00;
	localparam logic [4:0] ADR_CMD     = 5'h01;
	localparam logic [4:0] ADR_STAT    = 5'h02;
	localparam logic [4:0] ADR_IRQ     = 5'h03;
	localparam logic [4:0] ADR_IEN     = 5'h04;
	localparam logic [4:0] ADR_RXLVL   = 5'h05;
	localparam logic [4:0] ADR_TEC     = 5'h06;
	localparam logic [4:0] ADR_REC     = 5'h07;
	localparam logic [4:0] ADR_RXSTART = 5'h08;
	localparam logic [4:0] ADR_RXBYTES = 5'h09;
	localparam logic [4:0] ADR_TXB_LO  = 5'h10;
	localparam logic [4:0] ADR_TXB_HI  = 5'h1C;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int MODE_RM    = 0;
	localparam int CMD_SEND   = 0;
	localparam int CMD_CANCEL = 1;
	localparam int CMD_FREE   = 2;
	localparam int CMD_CLROVF = 3;
	localparam int CMD_LOOP   = 4;
	localparam int ST_BS      = 7;
	localparam int ST_ES      = 6;
	localparam int ST_TS      = 5;
	localparam int ST_RS      = 4;
	localparam int ST_TCS     = 3;
	localparam int ST_TBS     = 2;
	localparam int ST_DOS     = 1;
	localparam int ST_RBS     = 0;
	localparam int IRQ_BUSERR = 7;
	localparam int IRQ_OVF    = 3;
	localparam int IRQ_ERR    = 2;
	localparam int IRQ_TX     = 1;
	localparam int IRQ_RX     = 0;

	// ************************************************************
	// Reset values, limits and counts
	// ************************************************************
	localparam logic       RST_RM       = 1'b1;
	localparam logic       RST_TBS      = 1'b1;
	localparam logic [8:0] TEC_LIMIT    = 9'h0FF;
	localparam logic [8:0] TEC_BUSOFF   = 9'h07F;
	localparam logic [8:0] TEC_ERR_STEP = 9'h008;
	localparam logic [7:0] WARN_LIMIT   = 8'h60;
	localparam logic [6:0] BF_LAST      = 7'h7F;
	localparam logic [1:0] REL_DELAY    = 2'h2;
	localparam logic [6:0] FIFO_BYTES   = 7'h40;
	localparam int         Q_DEPTH      = 8;
	localparam int         TXB_LEN      = 13;

	// ************************************************************
	// Carriers to and from the protocol core
	// ************************************************************
	typedef struct packed {
		logic       tx_active;
		logic       rx_active;
		logic       tx_success;
		logic       tx_fail;
		logic       tx_err;
		logic       tx_ok;
		logic       rx_err;
		logic       rx_ok;
		logic       bus_free;
		logic       msg_valid;
		logic       msg_accepted;
		logic       msg_high_prio;
		logic [3:0] msg_len;
	} ccs_core_in_t;

	typedef struct packed {
		logic tx_go;
		logic single_shot;
		logic self_rx;
		logic halt;
	} ccs_core_out_t;

endpackage

// File: rtl/ccs_cmd_status.sv
`timescale 1ns/1ps
module ccs_cmd_status (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic [4:0]              addr,
	input  wire logic [7:0]              wdata,
	input  wire logic                    wr,
	input  wire logic                    rd,
	output logic      [7:0]              rdata,
	input  wire ccs_pkg::ccs_core_in_t   core_in,
	output ccs_pkg::ccs_core_out_t       core_out,
	output logic      [12:0][7:0]        tx_frame,
	output logic      [5:0]              rx_start_addr
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic                  rm;
		logic                  bs;
		logic                  es;
		logic                  ts;
		logic                  rs;
		logic                  send_done_flag;
		logic                  tx_buffer_free_flag;
		logic                  ovf;
		logic                  pend;
		logic                  single;
		logic                  self_rx;
		logic [7:0]            irq;
		logic [7:0]            ien;
		logic [7:0]            rx_lvl;
		logic [8:0]            tec;
		logic [7:0]            rec;
		logic [6:0]            bf_cnt;
		logic [7:0][3:0]       q_len;
		logic [7:0]            q_hp;
		logic [2:0]            q_wr;
		logic [2:0]            q_rd;
		logic [3:0]            q_cnt;
		logic [6:0]            bytes;
		logic [3:0]            hp_cnt;
		logic [5:0]            start;
		logic [3:0]            adv;
		logic [1:0]            rel_dly;
		logic [12:0][7:0]      txb;
		logic [7:0]            rdata;
	} ccs_state_t;

	localparam ccs_state_t S_RST = '{rm: ccs_pkg::RST_RM, tx_buffer_free_flag: ccs_pkg::RST_TBS, default: '0};

	ccs_state_t s_r;
	ccs_state_t s_nxt;
	logic [7:0] stat;
	logic       cmd_wr;
	logic       rel;
	logic [4:0] txb_idx;
	logic       txb_wr;

	// ************************************************************
	// Decode
	// ************************************************************
	// Command bits only live for the write cycle
	assign cmd_wr  = wr & (addr == ccs_pkg::ADR_CMD);
	assign rel     = cmd_wr & wdata[ccs_pkg::CMD_FREE] & (s_r.q_cnt != 4'h0);
	assign txb_idx = addr - ccs_pkg::ADR_TXB_LO;
	assign txb_wr  = wr & (addr >= ccs_pkg::ADR_TXB_LO) & (addr <= ccs_pkg::ADR_TXB_HI);

	// Flags register, fixed bit order, never written
	assign stat[ccs_pkg::ST_BS]  = s_r.bs;
	assign stat[ccs_pkg::ST_ES]  = s_r.es;
	assign stat[ccs_pkg::ST_TS]  = s_r.ts;
	assign stat[ccs_pkg::ST_RS]  = s_r.rs;
	assign stat[ccs_pkg::ST_TCS] = s_r.send_done_flag;
	assign stat[ccs_pkg::ST_TBS] = s_r.tx_buffer_free_flag;
	assign stat[ccs_pkg::ST_DOS] = s_r.ovf;
	assign stat[ccs_pkg::ST_RBS] = (s_r.q_cnt != 4'h0);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		logic [8:0] tec_t;
		logic [7:0] rec_t;
		logic       room;
		logic       rx_want;
		tec_t   = s_r.tec;
		rec_t   = s_r.rec;
		room    = 1'b0;
		rx_want = 1'b0;
		s_nxt   = s_r;
		s_nxt.rdata = 8'h00;

		// Read mux; flag reads clear all but receive, before any new set
		if (rd) begin
			unique case (addr)
				ccs_pkg::ADR_MODE:    s_nxt.rdata = {7'h00, s_r.rm};
				ccs_pkg::ADR_STAT:    s_nxt.rdata = stat;
				ccs_pkg::ADR_IRQ:     s_nxt.rdata = s_r.irq;
				ccs_pkg::ADR_IEN:     s_nxt.rdata = s_r.ien;
				ccs_pkg::ADR_RXLVL:   s_nxt.rdata = s_r.rx_lvl;
				ccs_pkg::ADR_TEC:     s_nxt.rdata = s_r.tec[7:0];
				ccs_pkg::ADR_REC:     s_nxt.rdata = s_r.rec;
				ccs_pkg::ADR_RXSTART: s_nxt.rdata = {2'b00, s_r.start};
				ccs_pkg::ADR_RXBYTES: s_nxt.rdata = {1'b0, s_r.bytes};
				default: begin
					// Command register is write-only and reads zero
					if (txb_wr | ((addr >= ccs_pkg::ADR_TXB_LO) & (addr <= ccs_pkg::ADR_TXB_HI))) begin
						s_nxt.rdata = s_r.txb[txb_idx[3:0]];
					end
				end
			endcase
			if (addr == ccs_pkg::ADR_IRQ) begin
				s_nxt.irq = s_r.irq & (8'h01 << ccs_pkg::IRQ_RX);
			end
		end

		// Software configuration
		if (wr & (addr == ccs_pkg::ADR_MODE)) begin
			s_nxt.rm = wdata[ccs_pkg::MODE_RM];
		end
		if (wr & (addr == ccs_pkg::ADR_IEN)) begin
			s_nxt.ien = wdata;
		end
		if (wr & (addr == ccs_pkg::ADR_RXLVL)) begin
			s_nxt.rx_lvl = wdata;
		end
		// Locked buffer swallows the byte with no trace
		if (txb_wr & s_r.tx_buffer_free_flag) begin
			s_nxt.txb[txb_idx[3:0]] = wdata;
		end

		// Error counters and bus-off entry
		if (!s_r.rm && !s_r.bs) begin
			if (core_in.tx_err) begin
				tec_t = s_r.tec + ccs_pkg::TEC_ERR_STEP;
			end else if (core_in.tx_ok && s_r.tec != 9'h000) begin
				tec_t = s_r.tec - 9'h001;
			end
			if (core_in.rx_err && s_r.rec != 8'hFF) begin
				rec_t = s_r.rec + 8'h01;
			end else if (core_in.rx_ok && s_r.rec != 8'h00) begin
				rec_t = s_r.rec - 8'h01;
			end
			s_nxt.tec = tec_t;
			s_nxt.rec = rec_t;
			if (tec_t > ccs_pkg::TEC_LIMIT) begin
				s_nxt.bs  = 1'b1;
				s_nxt.rm  = 1'b1;
				s_nxt.tec = ccs_pkg::TEC_BUSOFF;
				if (s_r.ien[ccs_pkg::IRQ_BUSERR]) begin
					s_nxt.irq[ccs_pkg::IRQ_BUSERR] = 1'b1;
				end
			end
		end else if (s_r.bs && !s_r.rm && core_in.bus_free) begin
			// Recovery waits for software to leave reset mode first
			if (s_r.bf_cnt == ccs_pkg::BF_LAST) begin
				s_nxt.bs     = 1'b0;
				s_nxt.tec    = 9'h000;
				s_nxt.rec    = 8'h00;
				s_nxt.bf_cnt = 7'h00;
			end else begin
				s_nxt.bf_cnt = s_r.bf_cnt + 7'h01;
				s_nxt.tec    = s_r.tec - 9'h001;
			end
		end
		// Warning held through bus-off so recovery count-down cannot drop it early
		s_nxt.es = s_nxt.bs | (s_nxt.tec >= {1'b0, ccs_pkg::WARN_LIMIT})
			| (s_nxt.rec >= ccs_pkg::WARN_LIMIT);
		if (s_r.ien[ccs_pkg::IRQ_ERR] && (s_nxt.es != s_r.es || s_nxt.bs != s_r.bs)) begin
			s_nxt.irq[ccs_pkg::IRQ_ERR] = 1'b1;
		end

		// Activity flags; reset mode forces idle
		s_nxt.ts = core_in.tx_active & ~s_nxt.rm;
		s_nxt.rs = core_in.rx_active & ~s_nxt.rm;

		// Transmit request handling; zero bits never touch the pending request
		if (cmd_wr & (wdata[ccs_pkg::CMD_SEND] | wdata[ccs_pkg::CMD_LOOP])) begin
			s_nxt.send_done_flag = 1'b0;
			if (s_r.tx_buffer_free_flag && !s_r.rm) begin
				s_nxt.pend    = 1'b1;
				s_nxt.single  = wdata[ccs_pkg::CMD_CANCEL];
				// Loopback only counts when plain send is absent
				s_nxt.self_rx = wdata[ccs_pkg::CMD_LOOP] & ~wdata[ccs_pkg::CMD_SEND];
			end
		end else if (cmd_wr & wdata[ccs_pkg::CMD_CANCEL]) begin
			// Core may already be on the bus before the flag registers
			if (!s_r.ts && !core_in.tx_active) begin
				s_nxt.pend = 1'b0;
			end else begin
				s_nxt.single = 1'b1;
			end
		end
		if (core_in.tx_success) begin
			s_nxt.pend = 1'b0;
			s_nxt.send_done_flag  = 1'b1;
		end
		// Single shot: request gone the moment the frame starts
		if (s_nxt.ts & ~s_r.ts & s_r.single) begin
			s_nxt.pend = 1'b0;
		end
		if (core_in.tx_fail & s_r.single) begin
			s_nxt.pend = 1'b0;
		end
		if (s_nxt.rm) begin
			s_nxt.pend = 1'b0;
		end
		s_nxt.tx_buffer_free_flag = ~s_nxt.pend & ~s_nxt.ts;
		if (s_r.ien[ccs_pkg::IRQ_TX] & s_nxt.tx_buffer_free_flag & ~s_r.tx_buffer_free_flag) begin
			s_nxt.irq[ccs_pkg::IRQ_TX] = 1'b1;
		end

		// Release of the head message
		if (rel) begin
			s_nxt.q_cnt   = s_r.q_cnt - 4'h1;
			s_nxt.bytes   = s_r.bytes - {3'b000, s_r.q_len[s_r.q_rd]};
			s_nxt.hp_cnt  = s_r.hp_cnt - {3'b000, s_r.q_hp[s_r.q_rd]};
			s_nxt.q_rd    = s_r.q_rd + 3'h1;
			s_nxt.adv     = s_r.q_len[s_r.q_rd];
			s_nxt.rel_dly = ccs_pkg::REL_DELAY;
		end else if (s_r.rel_dly != 2'h0) begin
			s_nxt.rel_dly = s_r.rel_dly - 2'h1;
			if (s_r.rel_dly == 2'h1) begin
				s_nxt.start = s_r.start + {2'b00, s_r.adv};
			end
		end

		// Overflow clear goes first so a same-cycle drop still sets it
		if (cmd_wr & wdata[ccs_pkg::CMD_CLROVF]) begin
			s_nxt.ovf = 1'b0;
		end
		// Store; frames ended by error never reach valid, so no overflow
		if (core_in.msg_valid & core_in.msg_accepted & ~s_r.rm) begin
			room = ((ccs_pkg::FIFO_BYTES - s_nxt.bytes) >= {3'b000, core_in.msg_len})
				& (s_nxt.q_cnt < 4'(ccs_pkg::Q_DEPTH));
			if (room) begin
				s_nxt.q_len[s_r.q_wr] = core_in.msg_len;
				s_nxt.q_hp[s_r.q_wr]  = core_in.msg_high_prio;
				s_nxt.q_wr   = s_r.q_wr + 3'h1;
				s_nxt.q_cnt  = s_nxt.q_cnt + 4'h1;
				s_nxt.bytes  = s_nxt.bytes + {3'b000, core_in.msg_len};
				s_nxt.hp_cnt = s_nxt.hp_cnt + {3'b000, core_in.msg_high_prio};
			end else begin
				s_nxt.ovf = 1'b1;
			end
		end
		if (s_r.ien[ccs_pkg::IRQ_OVF] & s_nxt.ovf & ~s_r.ovf) begin
			s_nxt.irq[ccs_pkg::IRQ_OVF] = 1'b1;
		end

		// Receive interrupt is a level on queue contents
		rx_want = ({1'b0, s_nxt.bytes} > s_r.rx_lvl) | (s_nxt.hp_cnt != 4'h0);
		if (!rx_want || (rel && s_nxt.q_cnt == 4'h0)) begin
			s_nxt.irq[ccs_pkg::IRQ_RX] = 1'b0;
		end else if (s_r.ien[ccs_pkg::IRQ_RX] && s_r.rel_dly == 2'h0 && s_nxt.rel_dly == 2'h0) begin
			s_nxt.irq[ccs_pkg::IRQ_RX] = 1'b1;
		end
	end

	// Single state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= S_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign rdata                = s_r.rdata;
	assign tx_frame             = s_r.txb;
	assign rx_start_addr        = s_r.start;
	assign core_out.tx_go       = s_r.pend & ~s_r.rm;
	assign core_out.single_shot = s_r.single;
	assign core_out.self_rx     = s_r.self_rx;
	assign core_out.halt        = s_r.rm;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_tcs_clear;
		cmd_wr && (wdata[ccs_pkg::CMD_SEND] || wdata[ccs_pkg::CMD_LOOP]) && !core_in.tx_success
			|=> !s_r.send_done_flag;
	endproperty
	a_tcs_clear: assert property (p_tcs_clear) else $error("done flag not cleared");

	property p_rel_hold;
		rel |=> !$rose(s_r.irq[ccs_pkg::IRQ_RX]) [*2] ##0 $stable(s_r.start);
	endproperty
	a_rel_hold: assert property (p_rel_hold) else $error("receive irq too early");

	property p_abort;
		cmd_wr && wdata[ccs_pkg::CMD_CANCEL] && !wdata[ccs_pkg::CMD_SEND]
			&& !wdata[ccs_pkg::CMD_LOOP] && !s_r.ts && !core_in.tx_active |=> !s_r.pend;
	endproperty
	a_abort: assert property (p_abort) else $error("cancel left request");

	property p_single;
		$rose(s_r.ts) && $past(s_r.single) |-> !s_r.pend;
	endproperty
	a_single: assert property (p_single) else $error("single shot request kept");

	property p_busoff;
		!s_r.rm && !s_r.bs && core_in.tx_err && s_r.tec > 9'h0F7
			|=> s_r.bs && s_r.rm && s_r.tec == 9'h07F;
	endproperty
	a_busoff: assert property (p_busoff) else $error("bus-off entry wrong");

	property p_warn;
		s_r.es == (s_r.bs || s_r.tec >= 9'h060 || s_r.rec >= 8'h60);
	endproperty
	a_warn: assert property (p_warn) else $error("warning flag mismatch");

	property p_ovf_irq;
		$rose(s_r.irq[ccs_pkg::IRQ_OVF]) |-> $rose(s_r.ovf);
	endproperty
	a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq without edge");

	property p_lock;
		txb_wr && !s_r.tx_buffer_free_flag |=> $stable(s_r.txb);
	endproperty
	a_lock: assert property (p_lock) else $error("locked buffer written");

	property p_rbs;
		stat[ccs_pkg::ST_RBS] == (s_r.bytes != 7'h00);
	endproperty
	a_rbs: assert property (p_rbs) else $error("message flag mismatch");

	property p_tx_irq;
		$rose(s_r.tx_buffer_free_flag) && $past(s_r.ien[ccs_pkg::IRQ_TX]) |-> s_r.irq[ccs_pkg::IRQ_TX];
	endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("transmit irq missing");

	property p_cmd_wo;
		rd && addr == ccs_pkg::ADR_CMD |=> rdata == 8'h00;
	endproperty
	a_cmd_wo: assert property (p_cmd_wo) else $error("command register readable");

endmodule

// File: dv/ccs_core_model.sv
`timescale 1ns/1ps
// ************************************************************
// Protocol core stand-in: plays the frames of the bus
// ************************************************************
module ccs_core_model (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire ccs_pkg::ccs_core_out_t core_out,
	input  wire ccs_pkg::ccs_core_in_t  inj,
	input  wire logic                   fail_mode,
	input  wire logic [3:0]             dly,
	output ccs_pkg::ccs_core_in_t       core_in,
	output logic      [7:0]             frame_cnt
);
	ccs_pkg::ccs_core_in_t pl;
	logic                  act;
	logic                  sr;
	logic [1:0]            st;
	logic [3:0]            cnt;

	// Bench pulses ride on top of the frame pulses
	always_comb begin
		core_in = inj | pl;
		core_in.tx_active = act | inj.tx_active;
	end

	// Frame sequencer; a request still up after a frame is retried
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pl <= '0;
			act <= 1'b0;
			sr <= 1'b0;
			st <= 2'h0;
			cnt <= 4'h0;
			frame_cnt <= 8'h00;
		end else begin
			pl <= '0;
			case (st)
				2'h0: if (core_out.tx_go && !core_out.halt) begin
					st <= 2'h1;
					cnt <= dly;
				end
				2'h1: if (!core_out.tx_go || core_out.halt) begin
					st <= 2'h0; // Withdrawn before start
				end else if (cnt == 4'h0) begin
					st <= 2'h2;
					cnt <= dly;
					act <= 1'b1;
					sr <= core_out.self_rx;
					frame_cnt <= frame_cnt + 8'h01;
				end else begin
					cnt <= cnt - 4'h1;
				end
				2'h2: if (core_out.halt || cnt == 4'h0) begin
					st <= 2'h3;
					act <= 1'b0; // Halt cuts the frame short
					pl.tx_success <= !fail_mode && !core_out.halt;
					pl.tx_fail <= fail_mode && !core_out.halt;
					pl.msg_valid <= sr && !fail_mode && !core_out.halt;
					pl.msg_accepted <= sr && !fail_mode;
					pl.msg_len <= 4'h5;
				end else begin
					cnt <= cnt - 4'h1;
				end
				// One idle cycle so a retry sees the fresh request
				default: st <= 2'h0;
			endcase
		end
	end
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
	logic                   clk;
	logic                   rst;
	logic [4:0]             addr;
	logic [7:0]             wdata;
	logic                   wr;
	logic                   rd;
	logic [7:0]             rdata;
	ccs_pkg::ccs_core_in_t  core_in;
	ccs_pkg::ccs_core_in_t  inj;
	ccs_pkg::ccs_core_out_t core_out;
	logic [12:0][7:0]       tx_frame;
	logic [5:0]             rx_start_addr;
	logic                   fail_mode;
	logic [3:0]             dly;
	logic [7:0]             frame_cnt;
	logic [7:0]             n;
	int                     err_total;
	int                     cmp_count;

	ccs_cmd_status u_ccs_cmd_status (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .core_in(core_in), .core_out(core_out),
		.tx_frame(tx_frame), .rx_start_addr(rx_start_addr));
	ccs_core_model u_ccs_core_model (.clk(clk), .rst(rst), .core_out(core_out), .inj(inj),
		.fail_mode(fail_mode), .dly(dly), .core_in(core_in), .frame_cnt(frame_cnt));

	// ************************************************************
	// Bus and compare helpers
	// ************************************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp, input string msg);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, exp, msg);
	endtask
	task automatic pulse(input ccs_pkg::ccs_core_in_t v);
		@(posedge clk);
		inj <= v;
		@(posedge clk);
		inj <= '0;
	endtask
	// Bounded wait until no request is up and no frame runs
	task automatic wait_frame;
		int i;
		i = 0;
		@(posedge clk);
		while ((core_out.tx_go | core_in.tx_active) !== 1'b0 && i < 200) begin
			@(posedge clk);
			i++;
		end
		#1 chk(8'(i < 200), 8'h01, "frame end");
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset;
		chk(core_out.halt, 8'h01, "halt after reset");
		rd_chk(ccs_pkg::ADR_STAT, 8'h04, "status reset");
		wr_reg(ccs_pkg::ADR_STAT, 8'hFF);
		rd_chk(ccs_pkg::ADR_STAT, 8'h04, "status read only");
		rd_chk(ccs_pkg::ADR_CMD, 8'h00, "command reads zero");
		rd_chk(5'h1F, 8'h00, "unmapped read");
		wr_reg(ccs_pkg::ADR_CMD, 8'hE0); // Reserved bits only
		wr_reg(ccs_pkg::ADR_CMD, 8'h01);
		chk(core_out.tx_go, 8'h00, "no send when halted");
		wr_reg(ccs_pkg::ADR_MODE, 8'h00);
		chk(core_out.halt, 8'h00, "running");
		$display("t_reset done");
	endtask
	task automatic t_send;
		wr_reg(ccs_pkg::ADR_IEN, 8'h0B);
		wr_reg(ccs_pkg::ADR_RXLVL, 8'h00);
		wr_reg(ccs_pkg::ADR_TXB_LO, 8'h5A);
		chk(tx_frame[0], 8'h5A, "buffer write");
		n = frame_cnt;
		dly = 4'h8;
		wr_reg(ccs_pkg::ADR_CMD, 8'h01);
		wr_reg(ccs_pkg::ADR_CMD, 8'h00); // Zero write keeps the request
		wr_reg(ccs_pkg::ADR_TXB_LO, 8'hA5);
		chk(tx_frame[0], 8'h5A, "locked write dropped");
		for (int i = 0; i < 50 && core_in.tx_active !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		rd_chk(ccs_pkg::ADR_STAT, 8'h20, "in frame");
		wait_frame;
		chk(frame_cnt - n, 8'h01, "one frame");
		rd_chk(ccs_pkg::ADR_STAT, 8'h0C, "done");
		rd_chk(ccs_pkg::ADR_IRQ, 8'h02, "tx irq");
		rd_chk(ccs_pkg::ADR_IRQ, 8'h00, "irq read clear");
		$display("t_send done");
	endtask
	task automatic t_single;
		logic [7:0] code [3];
		logic [7:0] lb [3];
		code = '{8'h03, 8'h12, 8'h13};
		lb = '{8'h00, 8'h01, 8'h00};
		fail_mode = 1'b1;
		dly = 4'h2;
		for (int k = 0; k < 3; k++) begin
			n = frame_cnt;
			wr_reg(ccs_pkg::ADR_CMD, code[k]);
			chk(core_out.single_shot, 8'h01, "single shot");
			chk(core_out.self_rx, lb[k], "loopback select");
			wait_frame;
			chk(frame_cnt - n, 8'h01, "no retry");
			rd_chk(ccs_pkg::ADR_STAT, 8'h04, "not done");
			rd_chk(ccs_pkg::ADR_IRQ, 8'h02, "tx irq");
		end
		fail_mode = 1'b0;
		$display("t_single done");
	endtask
	task automatic t_cancel;
		dly = 4'h8;
		n = frame_cnt;
		wr_reg(ccs_pkg::ADR_CMD, 8'h01);
		wr_reg(ccs_pkg::ADR_CMD, 8'h02);
		wait_frame;
		chk(frame_cnt - n, 8'h00, "cancelled");
		rd_chk(ccs_pkg::ADR_STAT, 8'h04, "not sent");
		rd_chk(ccs_pkg::ADR_IRQ, 8'h02, "tx irq");
		$display("t_cancel done");
	endtask
	task automatic t_loop;
		dly = 4'h8;
		wr_reg(ccs_pkg::ADR_CMD, 8'h11);
		chk(core_out.self_rx, 8'h00, "loopback ignored");
		wait_frame;
		rd_chk(ccs_pkg::ADR_STAT, 8'h0C, "plain send");
		rd_chk(ccs_pkg::ADR_IRQ, 8'h02, "tx irq");
		wr_reg(ccs_pkg::ADR_CMD, 8'h10);
		rd_chk(ccs_pkg::ADR_STAT, 8'h00, "done cleared");
		wait_frame;
		rd_chk(ccs_pkg::ADR_STAT, 8'h0D, "self received");
		rd_chk(ccs_pkg::ADR_IRQ, 8'h03, "rx and tx irq");
		wr_reg(ccs_pkg::ADR_CMD, 8'h04);
		rd_chk(ccs_pkg::ADR_STAT, 8'h0C, "queue empty");
		$display("t_loop done");
	endtask
	task automatic t_rx;
		ccs_pkg::ccs_core_in_t v;
		v = '0;
		v.msg_valid = 1'b1;
		v.msg_accepted = 1'b1;
		v.msg_len = 4'hD;
		repeat (5) pulse(v);
		rd_chk(ccs_pkg::ADR_RXBYTES, 8'h34, "stored bytes");
		rd_chk(ccs_pkg::ADR_STAT, 8'h0F, "overflow");
		rd_chk(ccs_pkg::ADR_IRQ, 8'h09, "overflow irq");
		pulse(v);
		rd_chk(ccs_pkg::ADR_IRQ, 8'h01, "no second overflow irq");
		wr_reg(ccs_pkg::ADR_CMD, 8'h08);
		rd_chk(ccs_pkg::ADR_STAT, 8'h0D, "overflow cleared");
		wr_reg(ccs_pkg::ADR_CMD, 8'h04);
		chk(rx_start_addr, 8'h05, "start held c1");
		@(posedge clk);
		#1 chk(rx_start_addr, 8'h05, "start held c2");
		@(posedge clk);
		#1 chk(rx_start_addr, 8'h12, "next message");
		repeat (3) wr_reg(ccs_pkg::ADR_CMD, 8'h04);
		rd_chk(ccs_pkg::ADR_STAT, 8'h0C, "all released");
		rd_chk(ccs_pkg::ADR_IRQ, 8'h00, "rx irq cleared");
		$display("t_rx done");
	endtask
	task automatic t_busoff;
		ccs_pkg::ccs_core_in_t v;
		v = '0;
		v.tx_err = 1'b1;
		repeat (11) pulse(v);
		rd_chk(ccs_pkg::ADR_STAT, 8'h0C, "below warning");
		pulse(v);
		rd_chk(ccs_pkg::ADR_STAT, 8'h4C, "warning at 96");
		repeat (19) pulse(v);
		rd_chk(ccs_pkg::ADR_TEC, 8'hF8, "counter 248");
		pulse(v);
		rd_chk(ccs_pkg::ADR_STAT, 8'hCC, "bus off");
		rd_chk(ccs_pkg::ADR_TEC, 8'h7F, "counter 127");
		chk(core_out.halt, 8'h01, "reset mode");
		wr_reg(ccs_pkg::ADR_MODE, 8'h00);
		v = '0;
		v.bus_free = 1'b1;
		pulse(v);
		rd_chk(ccs_pkg::ADR_TEC, 8'h7E, "count down");
		repeat (126) pulse(v);
		rd_chk(ccs_pkg::ADR_STAT, 8'hCC, "still off");
		pulse(v);
		rd_chk(ccs_pkg::ADR_STAT, 8'h0C, "bus on");
		$display("t_busoff done");
	endtask

	task automatic test_done;
		$display("Comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Free-running 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Hang guard, several times the expected run
	initial begin
		#200000;
		err_total++;
		$display("CHECK FAILED t=%0t watchdog", $time);
		test_done;
	end

	initial begin
		rst = 1'b1;
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
		inj = '0;
		fail_mode = 1'b0;
		dly = 4'h2;
		err_total = 0;
		cmp_count = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_send;
		t_single;
		t_cancel;
		t_loop;
		t_rx;
		t_busoff;
		test_done;
	end
endmodule
